// [design/xmb_pkg.sv]
// constants for the external data-memory bus block
// assumes a core that issues one move request at a time
package xmb_pkg;
   localparam int XMB_AUX_DEPTH = 1024;
   localparam int XMB_AUX_AW = 10;
   localparam logic [15:0] XMB_AUX_LAST = 16'h03FF;
   localparam int XMB_AUX_SEL_BIT = 4;
   localparam logic [7:0] XMB_P0_FILL = 8'hFF;
   localparam logic [7:0] XMB_SPECIAL_BASE = 8'h80;
   localparam logic [2:0] XMB_BIT_ADDR_LOW = 3'h0;
   localparam int XMB_ADDR_CYCLES = 2;
   localparam int XMB_SETUP_CYCLES = 1;
   localparam int XMB_STROBE_CYCLES = 3;
   localparam int XMB_HOLD_CYCLES = 1;
   localparam logic [1:0] XMB_CNT_W0 = 2'h0;
   localparam logic [7:0] XMB_CHIP_CTRL_ADDR = 8'h9F;
   localparam logic [7:0] XMB_CHIP_CTRL_RESET = 8'h00;
   typedef enum logic [5:0] {
      XMB_IDLE = 6'h01,
      XMB_ADDR = 6'h02,
      XMB_SETUP = 6'h04,
      XMB_STROBE = 6'h08,
      XMB_HOLD = 6'h10,
      XMB_AUX = 6'h20
   } xmb_state_type;
endpackage

// [design/xmb_aux_ram.sv]
// auxiliary ram store, 1024 bytes, registered read data
// assumes address and controls are synchronous to i_clock
module xmb_aux_ram
   import xmb_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_we,
   input wire logic [XMB_AUX_AW-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [XMB_AUX_DEPTH];

   always_ff @(posedge i_clock) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
   end
endmodule

// [design/xmb_special_decode.sv]
// decode of the internal direct/indirect address for special registers
// assumes the core presents one address per cycle with its mode
module xmb_special_decode
   import xmb_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic i_direct,
   input wire logic i_bit_access,
   output logic o_special_hit,
   output logic o_bit_ok,
   output logic o_upper_ram_hit
);
   function automatic logic upper_half(input logic [7:0] a);
      upper_half = (a >= XMB_SPECIAL_BASE);
   endfunction

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_special_hit <= 1'b0;
         o_bit_ok <= 1'b0;
         o_upper_ram_hit <= 1'b0;
      end else begin
         o_special_hit <= upper_half(i_addr) && i_direct;
         o_upper_ram_hit <= upper_half(i_addr) && !i_direct;
         o_bit_ok <= upper_half(i_addr) && i_direct && i_bit_access
            && (i_addr[2:0] == XMB_BIT_ADDR_LOW);
      end
   end
endmodule

// [design/xmb_bus.sv]
// external data-memory bus engine: aux ram or multiplexed external bus
// assumes the core holds i_req until o_done; chip control written at its special address
//
// Overview of operation
// - 1024 bytes aux ram at 000H-3FFH, reached only by external moves
// - pointer-pair moves give 16-bit address; index register moves give 8-bit
// - external bus used only while aux ram select bit 4 is clear
// - 16-bit access: port0 low address/data, port2 high, read and write strobes
// - bus pins taken from general i/o during any external access
// - 8-bit mode drives only port0 and strobes; port2 stays general i/o
// - low address and data multiplexed on port0, latch strobe marks address
// - low address held on port0 through falling edge of latch strobe
// - write data driven before write strobe and kept until after it
// - ram drives port0 on read; sampled just before read strobe ends
// - every external access loads 0FFH into the port0 output latch
// - special registers at 80-FFH respond only to direct addressing
// - only special registers ending in 0H or 8H allow single-bit access
module xmb_bus
   import xmb_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_req,
   input wire logic i_write,
   input wire logic i_wide,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_spec_we,
   input wire logic [7:0] i_spec_addr,
   input wire logic [7:0] i_spec_wdata,
   input wire logic i_spec_direct,
   input wire logic i_spec_bit,
   input wire logic [7:0] i_p0_gpio,
   input wire logic [7:0] i_p2_gpio,
   input wire logic [7:0] i_p0_in,
   output logic o_done,
   output logic [7:0] o_rdata,
   output logic o_busy,
   output logic o_aux_ram_select,
   output logic [7:0] o_p0_latch,
   output logic [7:0] o_p0_out,
   output logic [7:0] o_p0_oe,
   output logic [7:0] o_p2_out,
   output logic o_p2_own,
   output logic o_ale,
   output logic o_rd_n,
   output logic o_wr_n,
   output logic o_special_hit,
   output logic o_bit_ok,
   output logic o_upper_ram_hit
);
   xmb_state_type state_reg, state_next;
   logic [1:0] cnt_reg;
   logic [7:0] chip_control_reg;
   logic [15:0] addr_reg;
   logic [7:0] wdata_reg;
   logic write_reg, wide_reg;
   logic [7:0] aux_rdata;
   logic aux_we;
   logic start;
   logic cnt_end;
   logic [15:0] move_addr;

   // bus phases of an external access
   function automatic logic on_bus(input xmb_state_type s);
      on_bus = (s inside {XMB_ADDR, XMB_SETUP, XMB_STROBE, XMB_HOLD});
   endfunction

   // width of the access in flight or being taken now
   function automatic logic wide_next();
      wide_next = (state_reg == XMB_IDLE) ? i_wide : wide_reg;
   endfunction

   assign start = i_req && !o_busy && !o_done;
   // 8-bit moves carry no high byte, also toward aux ram
   assign move_addr = i_wide ? i_addr : {8'h00, i_addr[7:0]};
   assign aux_we = start && i_write && chip_control_reg[XMB_AUX_SEL_BIT] && (move_addr <= XMB_AUX_LAST);

   always_comb begin
      case (state_reg)
         XMB_ADDR: cnt_end = (cnt_reg == 2'(XMB_ADDR_CYCLES - 1));
         XMB_SETUP: cnt_end = (cnt_reg == 2'(XMB_SETUP_CYCLES - 1));
         XMB_STROBE: cnt_end = (cnt_reg == 2'(XMB_STROBE_CYCLES - 1));
         XMB_HOLD: cnt_end = (cnt_reg == 2'(XMB_HOLD_CYCLES - 1));
         default: cnt_end = 1'b1;
      endcase
   end

   // chip control register, written by direct special access only
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         chip_control_reg <= XMB_CHIP_CTRL_RESET;
      end else if (i_spec_we && i_spec_direct && i_spec_addr == XMB_CHIP_CTRL_ADDR) begin
         chip_control_reg <= i_spec_wdata;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_aux_ram_select <= 1'b0;
      end else begin
         o_aux_ram_select <= chip_control_reg[XMB_AUX_SEL_BIT];
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         XMB_IDLE: begin
            if (start) begin
               if (chip_control_reg[XMB_AUX_SEL_BIT]) begin
                  state_next = XMB_AUX;
               end else begin
                  state_next = XMB_ADDR;
               end
            end
         end
         XMB_ADDR: begin
            if (cnt_end) begin
               state_next = XMB_SETUP;
            end
         end
         XMB_SETUP: begin
            if (cnt_end) begin
               state_next = XMB_STROBE;
            end
         end
         XMB_STROBE: begin
            if (cnt_end) begin
               state_next = XMB_HOLD;
            end
         end
         XMB_HOLD: begin
            if (cnt_end) begin
               state_next = XMB_IDLE;
            end
         end
         XMB_AUX: state_next = XMB_IDLE;
         default: state_next = XMB_IDLE;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= XMB_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // phase counter restarts at every state change
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg <= XMB_CNT_W0;
      end else if (state_next != state_reg) begin
         cnt_reg <= XMB_CNT_W0;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
      end
   end

   // capture request; 8-bit moves keep only the low byte
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         addr_reg <= 16'h0000;
         wdata_reg <= 8'h00;
      end else if (start) begin
         addr_reg <= move_addr;
         wdata_reg <= i_wdata;
      end
   end

   // direction and width of the access in flight
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         write_reg <= 1'b0;
         wide_reg <= 1'b0;
      end else if (start) begin
         write_reg <= i_write;
         wide_reg <= i_wide;
      end
   end

   // aux ram is only reachable here, from external moves
   xmb_aux_ram u_aux_ram (
      .i_clock(i_clock),
      .i_we(aux_we),
      .i_addr(move_addr[XMB_AUX_AW-1:0]),
      .i_wdata(i_wdata),
      .o_rdata(aux_rdata)
   );

   xmb_special_decode u_special (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_addr(i_spec_addr),
      .i_direct(i_spec_direct),
      .i_bit_access(i_spec_bit),
      .o_special_hit(o_special_hit),
      .o_bit_ok(o_bit_ok),
      .o_upper_ram_hit(o_upper_ram_hit)
   );

   // port0 latch overwritten with all ones by any external access
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_p0_latch <= XMB_P0_FILL;
      end else if (state_reg == XMB_ADDR) begin
         o_p0_latch <= XMB_P0_FILL;
      end else if (i_spec_we && i_spec_direct && i_spec_addr == XMB_SPECIAL_BASE) begin
         o_p0_latch <= i_spec_wdata;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_busy <= 1'b0;
      end else begin
         o_busy <= (state_next != XMB_IDLE);
      end
   end

   // port2 taken from general i/o only for 16-bit accesses
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_p2_own <= 1'b0;
      end else begin
         o_p2_own <= on_bus(state_next) && wide_next();
      end
   end

   // latch strobe high in the first address cycle only
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ale <= 1'b0;
      end else begin
         o_ale <= (state_next == XMB_ADDR) && !(state_reg == XMB_ADDR && cnt_reg == 2'(XMB_ADDR_CYCLES - 2));
      end
   end

   // strobes low only in the strobe phase, one at a time
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rd_n <= 1'b1;
         o_wr_n <= 1'b1;
      end else begin
         o_rd_n <= !(state_next == XMB_STROBE && !write_reg);
         o_wr_n <= !(state_next == XMB_STROBE && write_reg);
      end
   end

   // port0: low address, then write data, else general i/o
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_p0_out <= XMB_P0_FILL;
         o_p0_oe <= 8'h00;
      end else if (state_next == XMB_ADDR) begin
         o_p0_out <= (state_reg == XMB_IDLE) ? i_addr[7:0] : addr_reg[7:0];
         o_p0_oe <= 8'hFF;
      end else if (write_reg && on_bus(state_next)) begin
         o_p0_out <= wdata_reg;
         o_p0_oe <= 8'hFF;
      end else begin
         o_p0_out <= i_p0_gpio;
         o_p0_oe <= 8'h00;
      end
   end

   // port2: high address for 16-bit accesses, else general i/o
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_p2_out <= 8'h00;
      end else if (on_bus(state_next) && wide_next()) begin
         o_p2_out <= (state_reg == XMB_IDLE) ? i_addr[15:8] : addr_reg[15:8];
      end else begin
         o_p2_out <= i_p2_gpio;
      end
   end

   // completion pulse after the hold phase or the aux cycle
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_done <= 1'b0;
      end else begin
         o_done <= (state_reg == XMB_AUX) || (state_reg == XMB_HOLD && cnt_end);
      end
   end

   // read data; external byte sampled in the last strobe cycle
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 8'h00;
      end else if (state_reg == XMB_AUX) begin
         o_rdata <= aux_rdata;
      end else if (state_reg == XMB_STROBE && cnt_end && !write_reg) begin
         o_rdata <= i_p0_in;
      end
   end
endmodule

// [dv/xmb_ext_ram.sv]
// behavioural external ram with transparent address latch on port0
// assumes port0 pin value from the engine and port2 pin level for the high byte
module xmb_ext_ram (
   input wire logic i_ale,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic [7:0] i_p0,
   input wire logic [7:0] i_p2,
   output logic [7:0] o_p0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:65535];
   logic [7:0] lat;
   logic [7:0] last = 8'h00;
   always_latch if (i_ale) lat <= i_p0;
   always @(posedge i_wr_n) mem[{i_p2, lat}] = i_p0;
   always @(posedge i_rd_n) last = mem[{i_p2, lat}];
   // released bus shows the inverse of the last byte
   assign o_p0 = !i_rd_n ? mem[{i_p2, lat}] : ~last;
endmodule

// [dv/xmb_bus_asserts.sv]
// timing checks on the external bus pins of the engine
// assumes binding onto xmb_bus with matching port names
module xmb_bus_asserts (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_wide,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic o_done,
   input wire logic o_busy,
   input wire logic o_aux_ram_select,
   input wire logic [7:0] o_p0_latch,
   input wire logic [7:0] o_p0_out,
   input wire logic [7:0] o_p0_oe,
   input wire logic [7:0] o_p2_out,
   input wire logic o_p2_own,
   input wire logic o_ale,
   input wire logic o_rd_n,
   input wire logic o_wr_n
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   chk_strobe_excl: assert property (o_rd_n || o_wr_n) else $error("both strobes low");
   chk_idle_strobes: assert property (!o_busy |-> o_rd_n && o_wr_n) else $error("strobe while idle");
   chk_ale_start: assert property ($rose(o_busy) && !o_aux_ram_select |-> o_ale && o_p0_oe == 8'hFF
      && o_p0_out == i_addr[7:0]) else $error("address phase wrong");
   chk_addr_hold: assert property ($fell(o_ale) |-> $stable(o_p0_out) && o_p0_oe == 8'hFF)
      else $error("address not held at latch close");
   chk_latch_fill: assert property ($rose(o_busy) && !o_aux_ram_select |=> o_p0_latch == 8'hFF)
      else $error("port0 latch not filled");
   chk_high_addr: assert property ($rose(o_busy) && !o_aux_ram_select |-> o_p2_own == i_wide
      && (!i_wide || o_p2_out == i_addr[15:8])) else $error("port2 use wrong");
   chk_wr_data: assert property (!o_wr_n || $rose(o_wr_n) |-> o_p0_oe == 8'hFF && o_p0_out == i_wdata)
      else $error("write data not driven");
   chk_rd_release: assert property (!o_rd_n |-> o_p0_oe == 8'h00) else $error("port0 driven in read");
   chk_ext_len: assert property ($rose(o_busy) && !o_aux_ram_select |-> !o_done [*7] ##1 o_done)
      else $error("external access length wrong");
   chk_aux_quiet: assert property ($rose(o_busy) && o_aux_ram_select |-> !o_ale && !o_p2_own ##1 o_done)
      else $error("aux access touched bus");
endmodule
bind xmb_bus xmb_bus_asserts u_chk (.*);

// [dv/testbench.sv]
// self-checking bench for the external data-memory bus engine
// assumes xmb_bus, its checker and the external ram model
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module testbench;
   import xmb_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clock, i_rst_n, i_req, i_write, i_wide, i_spec_we, i_spec_direct, i_spec_bit;
   logic [15:0] i_addr;
   logic [7:0] i_wdata, i_spec_addr, i_spec_wdata, i_p0_gpio, i_p2_gpio, i_p0_in;
   logic o_done, o_busy, o_aux_ram_select, o_p2_own, o_ale, o_rd_n, o_wr_n, o_special_hit, o_bit_ok, o_upper_ram_hit;
   logic [7:0] o_rdata, o_p0_latch, o_p0_out, o_p0_oe, o_p2_out, q;
   logic [31:0] r;
   logic [15:0] ta [12];
   logic [7:0] td [12];
   logic [7:0] tp [12];
   logic [7:0] aux [4];
   logic [9:0] al [4] = '{10'h000, 10'h3FF, 10'h005, 10'h2A7};
   int n_fail = 0, checks = 0, seed = 18, n, k;
   wire logic [7:0] p2_pin = o_p2_own ? o_p2_out : i_p2_gpio;
   xmb_bus uut (.*);
   xmb_ext_ram ram (.i_ale(o_ale), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_p0(o_p0_out), .i_p2(p2_pin), .o_p0(i_p0_in));
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end
   task automatic close_out;
      $display("checks %0d failures %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic exp_bit_ok(input logic [31:0] v);
      exp_bit_ok = v[7] & v[8] & v[9] & (v[2:0] == 3'h0);
   endfunction
   task automatic spec_wr(input logic [7:0] a, input logic [7:0] d);
      i_spec_addr <= a;
      i_spec_wdata <= d;
      i_spec_direct <= 1'b1;
      i_spec_we <= 1'b1;
      @(posedge i_clock);
      i_spec_we <= 1'b0;
      @(posedge i_clock);
   endtask
   task automatic mv(input logic w, input logic wd, input logic [15:0] a, input logic [7:0] d);
      i_write <= w;
      i_wide <= wd;
      i_addr <= a;
      i_wdata <= d;
      i_req <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_done !== 1'b1 && n < 30);
      q = o_rdata;
      if (n >= 30) n_fail++;
      i_req <= 1'b0;
      @(posedge i_clock);
   endtask
   initial begin
      {i_req, i_write, i_wide, i_spec_we, i_spec_direct, i_spec_bit, i_rst_n} = '0;
      {i_addr, i_wdata, i_spec_addr, i_spec_wdata, i_p0_gpio, i_p2_gpio} = '0;
      repeat (10) @(posedge i_clock);
      i_rst_n <= 1'b1;
      @(posedge i_clock);
      `CHK({o_rd_n, o_wr_n, o_ale, o_p0_latch}, {3'b110, 8'hFF})
      repeat (24) begin
         r = $random(seed);
         i_spec_addr <= r[7:0];
         i_spec_direct <= r[8];
         i_spec_bit <= r[9];
         @(posedge i_clock);
         @(posedge i_clock);
         `CHK(o_special_hit, r[7] & r[8])
         `CHK(o_upper_ram_hit, r[7] & ~r[8])
         `CHK(o_bit_ok, exp_bit_ok(r))
      end
      for (k = 0; k < 12; k++) begin
         r = $random(seed);
         ta[k] = r[15:0];
         td[k] = r[23:16];
         tp[k] = r[31:24];
         i_p2_gpio <= tp[k];
         i_p0_gpio <= r[7:0];
         spec_wr(XMB_SPECIAL_BASE, td[k]);
         mv(1'b1, k < 6, ta[k], td[k]);
         `CHK(o_p0_latch, 8'hFF)
         `CHK(o_p2_out, tp[k])
      end
      for (k = 0; k < 12; k++) begin
         i_p2_gpio <= tp[k];
         mv(1'b0, k < 6, ta[k], 8'h00);
         `CHK(q, td[k])
      end
      mv(1'b1, 1'b1, 16'h0005, 8'h5A);
      spec_wr(XMB_CHIP_CTRL_ADDR, 8'h10);
      @(posedge i_clock);
      `CHK(o_aux_ram_select, 1'b1)
      for (k = 0; k < 4; k++) begin
         r = $random(seed);
         aux[k] = r[7:0];
         mv(1'b1, 1'b1, {6'h00, al[k]}, aux[k]);
      end
      for (k = 0; k < 4; k++) begin
         mv(1'b0, 1'b1, {6'h00, al[k]}, 8'h00);
         `CHK(q, aux[k])
      end
      mv(1'b1, 1'b0, 16'hFC05, 8'hC3);
      mv(1'b0, 1'b1, 16'h0005, 8'h00);
      `CHK(q, 8'hC3)
      spec_wr(XMB_CHIP_CTRL_ADDR, 8'h00);
      mv(1'b0, 1'b1, 16'h0005, 8'h00);
      `CHK(q, 8'h5A)
      close_out();
   end
   initial begin
      #(3000 * 50);
      n_fail++;
      close_out();
   end
endmodule
